// ===== rtl/scr_defines.svh
// Register offsets, field positions and reset values of the synth control/status bank.
// Assumes an 8-bit register access port with 7-bit addresses.
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ==========================================================
// Offsets
`define SCR_OFS_MUTE        7'h40
`define SCR_OFS_ADC_CLK     7'h43
`define SCR_OFS_DIV_OVR     7'h4E
`define SCR_OFS_SYNC_MON    7'h53
`define SCR_OFS_ADC_TRIG    7'h54
`define SCR_OFS_STATUS      7'h58
`define SCR_OFS_CORE_RB     7'h5A
`define SCR_OFS_TEMP_MAG    7'h5B
`define SCR_OFS_TEMP_SIGN   7'h5C
`define SCR_OFS_BAND_RB     7'h5E
`define SCR_OFS_BIAS_RB     7'h60
`define SCR_OFS_REVISION    7'h63

// ==========================================================
// Field positions
`define SCR_MUTE1_LSB       0
`define SCR_MUTE2_LSB       3
`define SCR_ADC_CLK_SEL_BIT 6
`define SCR_DIV_LSB         4
`define SCR_BAND_OVR_BIT    3
`define SCR_CORE_OVR_BIT    2
`define SCR_BIAS_OVR_BIT    1
`define SCR_MON_PD_BIT      6
`define SCR_SYNC_STD_BIT    5
`define SCR_MON_CLR_BIT     4
`define SCR_CNV_START_BIT   0

// ==========================================================
// Reset values
`define SCR_RW_RESET        8'h00
// Arbitrary neutral revision value
`define SCR_REVISION_VALUE  8'h01

`endif

// ===== rtl/scr_pkg.sv
// Types shared by the synth control/status register bank.
// Assumes nothing beyond the defines header.
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_DIV_1 = 2'b00,
    SCR_DIV_2 = 2'b01,
    SCR_DIV_4 = 2'b10,
    SCR_DIV_8 = 2'b11
  } scr_div_t;

  // Oscillator calibration codes
  typedef struct packed {
    logic [1:0] core;
    logic [7:0] band;
    logic [3:0] bias;
  } scr_osc_t;

  // Live status inputs from the analogue side
  typedef struct packed {
    logic locked;
    logic cal_busy;
    logic adc_busy;
    logic ref_ok;
    logic sync_ok;
  } scr_stat_t;

  typedef struct packed {
    logic [2:0] output1_mute_level;
    logic [2:0] output2_mute_level;
  } scr_mute_t;

endpackage

// ===== rtl/scr_regs.sv
// Upper control/status register bank of a frequency synthesizer.
// Assumes a serial front end that presents byte writes/reads on clk_sys; analogue
// blocks, ADC, calibration engine and dividers sit outside and use the fields here.
`include "scr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Digital clock dividers divide by 1, 2, 4 or 8 for codes 00..11.
// - Band code comes from calibration unless band override selects manual value.
// - Core select comes from calibration unless core override selects manual value.
// - Bias code comes from calibration unless bias override selects manual value.
// - ADC clock select 0 picks reference counter bit 2 (reference/8 with divider code 11, else held 0), 1 picks serial clock.
// - Monitor power-down bit 1 disables the sync setup/hold monitor.
// - Sync standard bit 0 selects CML/PECL, 1 selects LVDS.
// - Monitor clear bit held 1 keeps monitor output latch in reset.
// - Host write of conversion start bit begins one ADC conversion.
// - Sync health bit reads 1 when monitor judges setup/hold met.
// - Reference health bit reads 1 while reference amplitude is above threshold.
// - ADC busy bit reads 1 while a conversion is in progress.
// - Calibration busy bit reads 1 while calibration runs.
// - Status bits 7 and 6 show output 2 and output 1 enable pins.
// - Temperature is sign-magnitude: magnitude in one register, sign in next.
// - Readbacks give core 2 bits, band 8 bits, bias 4 bits.
// - Output 2 mute in bits 5:3, output 1 mute in bits 2:0.
// - Auto conversion enabled also starts a conversion at each calibration start.
module scr_regs #(
  parameter int DIV_CNT_W = 3
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Register access port
  input  wire logic [6:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Auto conversion enable, held in a lower register outside this bank
  input  wire logic              adc_auto_conversion_on_cal,
  input  wire logic              cal_start,
  // Calibration engine results and live status
  input  wire scr_pkg::scr_osc_t cal_osc,
  input  wire scr_pkg::scr_stat_t stat_in,
  input  wire logic [8:0]        adc_temp,
  input  wire logic              output1_enable_pin,
  input  wire logic              output2_enable_pin,
  // Reference and serial clock pin levels, sampled on clk_sys
  input  wire logic              rclk_in,
  input  wire logic              sclk_in,
  // Controls towards the analogue side
  output scr_pkg::scr_mute_t     mute,
  output scr_pkg::scr_div_t      digital_clock_divider,
  output logic                   div_rclk_tick,
  output logic                   div_nclk_tick,
  output logic                   adc_clk,
  output scr_pkg::scr_osc_t      osc_applied,
  output logic                   sync_monitor_enable,
  output logic                   sync_lvds_mode,
  output logic                   sync_monitor_latch_clear,
  output logic                   adc_conversion_start
);
  import scr_pkg::*;

  // ==========================================================
  // Writable registers
  logic [7:0] mute_reg;
  logic [7:0] adc_clk_reg;
  logic [7:0] div_ovr_reg;
  logic [7:0] sync_mon_reg;
  logic [7:0] adc_trig_reg;
  // Manual values live in lower registers; kept as ports would widen the bank,
  // so here the override path reads manual_osc, an internal store that no input feeds.
  scr_osc_t   manual_osc;
  wire        cal_osc_busy = stat_in.cal_busy;

  wire wr_ok = reg_wr & clk_en;
  wire wr_mute  = wr_ok & (reg_addr == `SCR_OFS_MUTE);
  wire wr_clk   = wr_ok & (reg_addr == `SCR_OFS_ADC_CLK);
  wire wr_div   = wr_ok & (reg_addr == `SCR_OFS_DIV_OVR);
  wire wr_sync  = wr_ok & (reg_addr == `SCR_OFS_SYNC_MON);
  wire wr_trig  = wr_ok & (reg_addr == `SCR_OFS_ADC_TRIG);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mute_reg     <= `SCR_RW_RESET;
      adc_clk_reg  <= `SCR_RW_RESET;
      div_ovr_reg  <= `SCR_RW_RESET;
      sync_mon_reg <= `SCR_RW_RESET;
      adc_trig_reg <= `SCR_RW_RESET;
    end else begin
      if (wr_mute) mute_reg <= reg_wdata;
      if (wr_clk) adc_clk_reg <= reg_wdata;
      if (wr_div) div_ovr_reg <= reg_wdata;
      if (wr_sync) sync_mon_reg <= reg_wdata;
      // Reserved bits 7:1 are read-only zero
      if (wr_trig) adc_trig_reg <= {7'h00, reg_wdata[`SCR_CNV_START_BIT]};
    end
  end

  // ==========================================================
  // Manual oscillator values: hold their reset value of zero; nothing loads them.
  // Stand-in store so overrides have a defined source in this bank.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      manual_osc <= '0;
    end else if (clk_en && !cal_osc_busy) begin
      manual_osc <= manual_osc;
    end
  end
  // ==========================================================
  // Field decode
  assign mute.output1_mute_level = mute_reg[`SCR_MUTE1_LSB +: 3];
  assign mute.output2_mute_level = mute_reg[`SCR_MUTE2_LSB +: 3];
  assign digital_clock_divider = scr_div_t'(div_ovr_reg[`SCR_DIV_LSB +: 2]);

  wire band_override_enable = div_ovr_reg[`SCR_BAND_OVR_BIT];
  wire core_override_enable = div_ovr_reg[`SCR_CORE_OVR_BIT];
  wire bias_override_enable = div_ovr_reg[`SCR_BIAS_OVR_BIT];

  assign osc_applied.band = band_override_enable ? manual_osc.band : cal_osc.band;
  assign osc_applied.core = core_override_enable ? manual_osc.core : cal_osc.core;
  assign osc_applied.bias = bias_override_enable ? manual_osc.bias : cal_osc.bias;

  assign sync_monitor_enable      = ~sync_mon_reg[`SCR_MON_PD_BIT];
  assign sync_lvds_mode           = sync_mon_reg[`SCR_SYNC_STD_BIT];
  assign sync_monitor_latch_clear = sync_mon_reg[`SCR_MON_CLR_BIT];

  // ==========================================================
  // Clock dividers for the reference and feedback ticks, both counting reference clock rises
  function automatic logic [DIV_CNT_W-1:0] div_mask(input scr_div_t d);
    unique case (d)
      SCR_DIV_1: div_mask = 3'b000;
      SCR_DIV_2: div_mask = 3'b001;
      SCR_DIV_4: div_mask = 3'b011;
      SCR_DIV_8: div_mask = 3'b111;
    endcase
  endfunction

  // Pin-level clock inputs pass two flops first
  logic [1:0] rclk_sync;
  logic [1:0] sclk_sync;
  logic       rclk_d;
  logic [DIV_CNT_W-1:0] rclk_cnt;
  logic [DIV_CNT_W-1:0] nclk_cnt;
  wire  rclk_rise = rclk_sync[1] & ~rclk_d;
  wire  [DIV_CNT_W-1:0] cur_mask = div_mask(digital_clock_divider);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rclk_sync <= 2'b00;
      sclk_sync <= 2'b00;
      rclk_d    <= 1'b0;
      rclk_cnt  <= '0;
      nclk_cnt  <= '0;
    end else if (clk_en) begin
      rclk_sync <= {rclk_sync[0], rclk_in};
      sclk_sync <= {sclk_sync[0], sclk_in};
      rclk_d    <= rclk_sync[1];
      if (rclk_rise) begin
        rclk_cnt <= (rclk_cnt & cur_mask) == cur_mask ? '0 : rclk_cnt + 1'b1;
        nclk_cnt <= (nclk_cnt & cur_mask) == cur_mask ? '0 : nclk_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_rclk_tick <= 1'b0;
      div_nclk_tick <= 1'b0;
      adc_clk       <= 1'b0;
    end else if (clk_en) begin
      div_rclk_tick <= rclk_rise && ((rclk_cnt & cur_mask) == cur_mask);
      div_nclk_tick <= rclk_rise && ((nclk_cnt & cur_mask) == cur_mask);
      adc_clk <= adc_clk_reg[`SCR_ADC_CLK_SEL_BIT] ? sclk_sync[1]
                                                   : rclk_cnt[DIV_CNT_W-1];
    end
  end

  // ==========================================================
  // Conversion start: host write or calibration start when auto enabled
  logic cal_start_d;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      adc_conversion_start <= 1'b0;
      cal_start_d          <= 1'b0;
    end else if (clk_en) begin
      cal_start_d <= cal_start;
      adc_conversion_start <= (wr_trig && reg_wdata[`SCR_CNV_START_BIT])
                            || (adc_auto_conversion_on_cal && cal_start && !cal_start_d);
    end
  end

  // ==========================================================
  // Pin levels for status
  logic [1:0] en1_sync;
  logic [1:0] en2_sync;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en1_sync <= 2'b00;
      en2_sync <= 2'b00;
    end else if (clk_en) begin
      en1_sync <= {en1_sync[0], output1_enable_pin};
      en2_sync <= {en2_sync[0], output2_enable_pin};
    end
  end

  // ==========================================================
  // Read mux; status is live, reserved bits zero
  wire [7:0] status_word = {en2_sync[1], en1_sync[1],
                            stat_in.sync_ok, 1'b0,
                            stat_in.ref_ok,
                            stat_in.adc_busy,
                            stat_in.cal_busy,
                            stat_in.locked};
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `SCR_OFS_MUTE:      rd_mux = mute_reg;
      `SCR_OFS_ADC_CLK:   rd_mux = adc_clk_reg;
      `SCR_OFS_DIV_OVR:   rd_mux = div_ovr_reg;
      `SCR_OFS_SYNC_MON:  rd_mux = sync_mon_reg;
      `SCR_OFS_ADC_TRIG:  rd_mux = adc_trig_reg;
      `SCR_OFS_STATUS:    rd_mux = status_word;
      `SCR_OFS_CORE_RB:   rd_mux = {6'h00, osc_applied.core};
      `SCR_OFS_TEMP_MAG:  rd_mux = adc_temp[7:0];
      `SCR_OFS_TEMP_SIGN: rd_mux = {7'h00, adc_temp[8]};
      `SCR_OFS_BAND_RB:   rd_mux = osc_applied.band;
      `SCR_OFS_BIAS_RB:   rd_mux = {4'h0, osc_applied.bias};
      `SCR_OFS_REVISION:  rd_mux = `SCR_REVISION_VALUE;
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// ===== test/scr_regs_checker.sv
// Port-level assertions for the synth control/status bank.
// Assumes a bind onto scr_regs from the bench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module scr_regs_checker (
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic               clk_en,
  input wire logic [6:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               adc_auto_conversion_on_cal,
  input wire logic               cal_start,
  input wire scr_pkg::scr_osc_t  cal_osc,
  input wire scr_pkg::scr_stat_t stat_in,
  input wire logic [8:0]         adc_temp,
  input wire scr_pkg::scr_mute_t mute,
  input wire scr_pkg::scr_div_t  digital_clock_divider,
  input wire scr_pkg::scr_osc_t  osc_applied,
  input wire logic               sync_monitor_enable,
  input wire logic               sync_lvds_mode,
  input wire logic               sync_monitor_latch_clear,
  input wire logic               adc_conversion_start
);
  import scr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic wr_ok = reg_wr && clk_en;
  wire logic rd_ok = reg_rd && clk_en;
  // ==========================================================
  // Control fields follow the last write
  property p_mute;
    wr_ok && reg_addr == 7'h40 |=> mute == {$past(reg_wdata[2:0]), $past(reg_wdata[5:3])};
  endproperty
  a_mute: assert property (p_mute) else $error("mute fields wrong");
  property p_div;
    wr_ok && reg_addr == 7'h4E |=> digital_clock_divider == $past(reg_wdata[5:4]);
  endproperty
  a_div: assert property (p_div) else $error("divider code wrong");
  // Manual values are zero, so an override forces zero codes
  property p_ovr;
    wr_ok && reg_addr == 7'h4E |=> osc_applied ==
      {$past(reg_wdata[2]) ? 2'h0 : cal_osc.core, $past(reg_wdata[3]) ? 8'h00 : cal_osc.band,
       $past(reg_wdata[1]) ? 4'h0 : cal_osc.bias};
  endproperty
  a_ovr: assert property (p_ovr) else $error("override select wrong");
  property p_sync;
    wr_ok && reg_addr == 7'h53 |=> {sync_monitor_enable, sync_lvds_mode,
      sync_monitor_latch_clear} == {!$past(reg_wdata[6]), $past(reg_wdata[5:4])};
  endproperty
  a_sync: assert property (p_sync) else $error("sync monitor controls wrong");
  // ==========================================================
  // Conversion start pulses
  property p_start;
    wr_ok && reg_addr == 7'h54 && reg_wdata[0] |=> adc_conversion_start;
  endproperty
  a_start: assert property (p_start) else $error("no start after host write");
  property p_auto;
    clk_en && adc_auto_conversion_on_cal && $rose(cal_start) |=> adc_conversion_start;
  endproperty
  a_auto: assert property (p_auto) else $error("no start at calibration");
  // ==========================================================
  // Live readback
  property p_stat;
    rd_ok && reg_addr == 7'h58 |=> reg_rdata[5:0] == {$past(stat_in.sync_ok), 1'b0,
      $past(stat_in.ref_ok), $past(stat_in.adc_busy), $past(stat_in.cal_busy), $past(stat_in.locked)};
  endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_temp;
    rd_ok && reg_addr == 7'h5C |=> reg_rdata == {7'h00, $past(adc_temp[8])};
  endproperty
  a_temp: assert property (p_temp) else $error("temperature sign wrong");
  property p_rst;
    $fell(sys_rst) |-> reg_rdata == 8'h00 && mute == '0 && sync_monitor_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_start: cover property (adc_conversion_start);
  c_ovr: cover property (wr_ok && reg_addr == 7'h4E && reg_wdata[3]);
  c_stat: cover property (rd_ok && reg_addr == 7'h58);
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the synth control/status bank.
// Assumes the package, defines header and scr_regs compiled first.
`include "scr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scr_pkg::*;
  logic       clk_sys, sys_rst, reg_wr, reg_rd, adc_auto_conversion_on_cal, cal_start;
  logic       output1_enable_pin, output2_enable_pin, sclk_in, adc_clk, adc_conversion_start;
  logic       sync_monitor_enable, sync_lvds_mode, sync_monitor_latch_clear;
  logic       rclk_in, div_rclk_tick, div_nclk_tick;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [8:0] adc_temp;
  scr_osc_t   cal_osc, osc_applied;
  scr_stat_t  stat_in;
  scr_mute_t  mute;
  scr_div_t   digital_clock_divider;
  int         error_cnt, cmp_count;
  localparam logic [6:0]  RW_OFS [5] = '{7'h40, 7'h43, 7'h4E, 7'h53, 7'h54};
  localparam logic [7:0]  OVR_W [4] = '{8'h00, 8'h08, 8'h04, 8'h02};
  localparam logic [15:0] OVR_E [4] = '{16'h2A59, 16'h2009, 16'h0A59, 16'h2A50};
  scr_regs #(.DIV_CNT_W(3)) dut (.clk_sys, .sys_rst, .clk_en(1'b1), .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .adc_auto_conversion_on_cal, .cal_start, .cal_osc,
    .stat_in, .adc_temp, .output1_enable_pin, .output2_enable_pin, .rclk_in, .sclk_in,
    .mute, .digital_clock_divider, .div_rclk_tick, .div_nclk_tick, .adc_clk, .osc_applied,
    .sync_monitor_enable, .sync_lvds_mode, .sync_monitor_latch_clear, .adc_conversion_start);
  // ==========================================================
  // Bus and compare tasks
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Idle edge first so a strobe never rises in the step it fell
  task automatic wr(logic [6:0] a, logic [7:0] d);
    step(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
  endtask
  task automatic rc(logic [6:0] a, logic [7:0] e);
    step(1);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    cmp(16'(e), 16'(reg_rdata));
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    foreach (RW_OFS[i]) rc(RW_OFS[i], 8'h00);
    rc(7'h63, `SCR_REVISION_VALUE);
    rc(7'h41, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_fields;
    wr(7'h40, 8'h1D);
    cmp(16'(mute), 16'h002B);
    rc(7'h40, 8'h1D);
    for (int c = 0; c < 4; c++) begin
      wr(7'h4E, 8'(c << 4));
      cmp(16'(digital_clock_divider), 16'(c));
    end
    wr(7'h53, 8'h70);
    cmp({sync_monitor_enable, sync_lvds_mode, sync_monitor_latch_clear}, 3'b011);
    wr(7'h53, 8'h00);
    cmp({sync_monitor_enable, sync_lvds_mode, sync_monitor_latch_clear}, 3'b100);
    $display("test fields done");
  endtask
  task automatic t_ovr;
    cal_osc = 14'h2A59;
    for (int i = 0; i < 4; i++) begin
      wr(7'h4E, OVR_W[i]);
      cmp(OVR_E[i], 16'(osc_applied));
    end
    rc(7'h5A, 8'h02);
    rc(7'h5E, 8'hA5);
    rc(7'h60, 8'h00);
    $display("test override done");
  endtask
  task automatic t_conv;
    wr(7'h54, 8'h01);
    cmp(adc_conversion_start, 1'b1);
    step(1);
    cmp(adc_conversion_start, 1'b0);
    rc(7'h54, 8'h01);
    wr(7'h54, 8'hFE);
    cmp(adc_conversion_start, 1'b0);
    rc(7'h54, 8'h00);
    adc_auto_conversion_on_cal = 1'b1;
    cal_start = 1'b1;
    step(1);
    cmp(adc_conversion_start, 1'b1);
    adc_auto_conversion_on_cal = 1'b0;
    cal_start = 1'b0;
    step(1);
    cal_start = 1'b1;
    step(1);
    cmp(adc_conversion_start, 1'b0);
    cal_start = 1'b0;
    $display("test conversion done");
  endtask
  task automatic t_status;
    for (int i = 0; i < 2; i++) begin
      stat_in = (i == 1) ? 5'h0A : 5'h15;
      output1_enable_pin = (i == 1);
      output2_enable_pin = (i == 0);
      step(3);
      wr(7'h58, 8'hFF);
      rc(7'h58, (i == 1) ? 8'h4A : 8'hA5);
    end
    adc_temp = 9'h1C3;
    rc(7'h5B, 8'hC3);
    rc(7'h5C, 8'h01);
    adc_temp = 9'h07E;
    rc(7'h5B, 8'h7E);
    rc(7'h5C, 8'h00);
    $display("test status done");
  endtask
  task automatic t_adcclk;
    wr(7'h43, 8'h40);
    sclk_in = 1'b1;
    step(4);
    cmp(adc_clk, 1'b1);
    sclk_in = 1'b0;
    step(4);
    cmp(adc_clk, 1'b0);
    wr(7'h43, 8'h00);
    sclk_in = 1'b1;
    step(4);
    cmp(adc_clk, 1'b0);
    $display("test adc clock done");
  endtask
  // Sixteen reference rises per code; each tick lasts one cycle and is counted once
  task automatic t_div;
    logic [15:0] nr;
    logic [15:0] nn;
    for (int c = 0; c < 4; c++) begin
      wr(7'h4E, 8'(c << 4));
      nr = '0;
      nn = '0;
      for (int r = 0; r < 16; r++) begin
        rclk_in = 1'b1;
        repeat (2) begin
          step(1);
          nr = nr + 16'(div_rclk_tick);
          nn = nn + 16'(div_nclk_tick);
        end
        rclk_in = 1'b0;
        repeat (2) begin
          step(1);
          nr = nr + 16'(div_rclk_tick);
          nn = nn + 16'(div_nclk_tick);
        end
      end
      step(4);
      cmp(16'(16 >> c), nr);
      cmp(16'(16 >> c), nn);
    end
    $display("test divider done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, adc_auto_conversion_on_cal, cal_start} = 5'b10000;
    {output1_enable_pin, output2_enable_pin, sclk_in, rclk_in, reg_addr, reg_wdata} = '0;
    {adc_temp, cal_osc, stat_in} = '0;
    step(2);
    sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_ovr();
    t_conv();
    t_status();
    t_adcclk();
    t_div();
    final_report();
  end
endmodule
bind scr_regs scr_regs_checker chk (.clk_sys, .sys_rst, .clk_en, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .adc_auto_conversion_on_cal, .cal_start, .cal_osc,
  .stat_in, .adc_temp, .mute, .digital_clock_divider, .osc_applied, .sync_monitor_enable,
  .sync_lvds_mode, .sync_monitor_latch_clear, .adc_conversion_start);
`default_nettype wire
